//--- dmaxb_regs.svh
`ifndef DMAXB_REGS_SVH
`define DMAXB_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DMAXB_CESC_IDX 8'h3e
`define DMAXB_CESC_ADDR 12'h0f8
`define DMAXB_MODE_BASE 12'h000
`define DMAXB_SRC_BASE 12'h040
`define DMAXB_DST_BASE 12'h080
`define DMAXB_CNT_BASE 12'h0c0
`define DMAXB_IDX_BASE 12'h100
`define DMAXB_PREC_ADDR 12'h180
`define DMAXB_BANK_SWITCH_CONTROL_REG_ADDR 12'h184
`define DMAXB_STAT_ADDR 12'h188
`define DMAXB_CPUREQ_ADDR 12'h18c

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DMAXB_CESC_SET_BIT 15
`define DMAXB_MODE_DINT_BIT 14
`define DMAXB_MODE_CHANNEL_INTERRUPT_MODE_BIT 13
`define DMAXB_MODE_SEXT_BIT 11
`define DMAXB_MODE_DEXT_BIT 5
`define DMAXB_MODE_RESET 16'h0000
`define DMAXB_BANK_SWITCH_CONTROL_REG_RESET 16'h0000
`define DMAXB_BANK_SWITCH_CONTROL_REG_CONSECUTIVE_READ_SELECT_BIT 0
`define DMAXB_BANK_SWITCH_CONTROL_REG_WAIT_LSB 4
`define DMAXB_BANK_SWITCH_CONTROL_REG_DIV_LSB 12
`define DMAXB_WAIT_MAX 4'hE
`define DMAXB_BANK_BIT 15

`endif

//--- dmaxb_pkg.sv
package dmaxb_pkg;
	typedef enum logic [2:0] {
		DMAXB_IDLE = 3'b000,
		DMAXB_LEAD = 3'b001,
		DMAXB_ACT = 3'b010,
		DMAXB_TRAIL = 3'b011,
		DMAXB_BANK = 3'b100
	} dmaxb_phase_t;
	typedef enum logic [1:0] {
		DMAXB_PS = 2'b00,
		DMAXB_DS = 2'b01,
		DMAXB_IO = 2'b10,
		DMAXB_RSV = 2'b11
	} dmaxb_space_t;
	typedef logic [15:0] dmaxb_word_t;
endpackage : dmaxb_pkg

//--- dmaxb_top.sv
`timescale 1ns/1ps
`include "dmaxb_regs.svh"
// Function
// [RULE1] lone read is lead, active, trail
// [RULE2] consecutive burst of n reads takes 2+n
// [RULE3] every write takes three bus clocks; the code adds the programmed wait states to the active phase
// [RULE4] sequencer clock gated while bus idle
// [RULE5] bank cycle when crossing 32K boundary; a consecutive read burst takes its first read past the crossing with no bank cycle, then ends
// [RULE6] wait states programmable up to 14
// [RULE7] wait states stretch only active phase
// [RULE8] bus clock divided by 1 to 4; the code's bus_clock_out pin only pulses at divide by 3 and 4
// [RULE9] six channels each hold own context
// [RULE10] dma wins over cpu requests
// [RULE11] address hold, inc, dec or index
// [RULE12] half and full block interrupts
// [RULE13] double word as two 16-bit moves
// [RULE14] one external read, one external write channel
// [RULE15] ext write at least 8, read 11
// [RULE16] loser stalled until owner transfer ends
// [RULE17] external moves are single 16-bit words
// [RULE18] unsupported external transfer kinds refused
// [RULE19] space select bits 5 and 11
// [RULE20] destination space field encoding
// [RULE21] completion clears channel enable bit
// [RULE22] set/clear register acts on selected enables
// [RULE23] no interrupt when interrupt enable clear
// [RULE24] write and completion both applied; the code lets the completion clear win over a same-cycle enable write
module dmaxb_top #(
	parameter int NCH = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic bus_clock_out,
	output logic [15:0] xbus_addr,
	output logic [15:0] xbus_wdata,
	output logic xbus_data_oe,
	input wire logic [15:0] xbus_rdata,
	output logic xbus_strobe_n,
	output logic xbus_rw,
	output logic [1:0] xbus_space,
	output logic xbus_bank_cycle,
	output logic xbus_clk_gate,
	output logic cpu_stall,
	output logic [NCH-1:0] chan_int
);
	import dmaxb_pkg::*;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [15:0] mode_q [NCH];
	logic [15:0] src_q [NCH];
	logic [15:0] dst_q [NCH];
	logic [15:0] cnt_q [NCH];
	logic [15:0] len_q [NCH];
	logic [15:0] idx_q [NCH];
	logic [NCH-1:0] en_q;
	logic [15:0] bank_switch_control_reg_q;
	logic cpureq_q;
	logic [15:0] rdata_q;
	logic [15:0] xin1_q, xin2_q;

	wire wr_acc = psel & penable & pwrite & clk_en;
	wire [2:0] reg_ch = paddr[4:2];
	wire [11:0] reg_grp = {paddr[11:5], 5'b0_0000};
	wire ch_ok = reg_ch < 3'(NCH);
	wire hit_cesc = paddr == `DMAXB_CESC_ADDR;
	wire hit_prec = paddr == `DMAXB_PREC_ADDR;
	wire hit_bank_switch_control_reg = paddr == `DMAXB_BANK_SWITCH_CONTROL_REG_ADDR;
	wire hit_stat = paddr == `DMAXB_STAT_ADDR;
	wire hit_cpur = paddr == `DMAXB_CPUREQ_ADDR;
	wire grp_hit = ch_ok && (reg_grp == `DMAXB_MODE_BASE || reg_grp == `DMAXB_SRC_BASE
		|| reg_grp == `DMAXB_DST_BASE || reg_grp == `DMAXB_CNT_BASE
		|| reg_grp == `DMAXB_IDX_BASE);
	wire mapped = grp_hit | hit_cesc | hit_prec | hit_bank_switch_control_reg | hit_stat | hit_cpur;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	function automatic logic [15:0] grp_read(input logic [11:0] g, input logic [2:0] c);
		logic [15:0] r;
		r = 16'h0000;
		if (c < 3'(NCH)) begin
			case (g)
				`DMAXB_MODE_BASE: r = mode_q[c];
				`DMAXB_SRC_BASE: r = src_q[c];
				`DMAXB_DST_BASE: r = dst_q[c];
				`DMAXB_CNT_BASE: r = cnt_q[c];
				`DMAXB_IDX_BASE: r = idx_q[c];
				default: r = 16'h0000;
			endcase
		end
		return r;
	endfunction : grp_read

	dmaxb_phase_t ph_q;
	wire [15:0] stat_w = {12'h000, 1'b0, ph_q};
	wire [15:0] rd_w = hit_prec ? 16'(en_q) : hit_bank_switch_control_reg ? bank_switch_control_reg_q : hit_stat ? stat_w
		: hit_cpur ? {15'h0000, cpureq_q} : grp_read(reg_grp, reg_ch);
	assign prdata = {16'h0000, rd_w};

	// ----------------------------------------
	// channel selection
	// ----------------------------------------
	function automatic logic ext_src(input logic [15:0] m);
		return m[`DMAXB_MODE_SEXT_BIT]; // [RULE19]
	endfunction : ext_src
	function automatic logic ext_dst(input logic [15:0] m);
		return m[`DMAXB_MODE_DEXT_BIT]; // [RULE19]
	endfunction : ext_dst

	// a channel may run when enabled, has count left, and is a legal kind
	logic [NCH-1:0] legal;
	logic [2:0] first_rd, first_wr;
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_legal
			// ext-to-ext refused; sync and double-word kinds are not checked
			assign legal[gi] = en_q[gi] && cnt_q[gi] != 16'h0000
				&& !(ext_src(mode_q[gi]) && ext_dst(mode_q[gi])) // [RULE18]
				&& mode_q[gi][1:0] != DMAXB_RSV; // [RULE20]
		end
	endgenerate

	// lowest channel with external read; lowest other with external write
	always_comb begin
		first_rd = 3'd7;
		first_wr = 3'd7;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (legal[i] && ext_src(mode_q[i]))
				first_rd = 3'(i);
			if (legal[i] && ext_dst(mode_q[i]) && !ext_src(mode_q[i]))
				first_wr = 3'(i);
		end
	end
	// at most two channels compete for the bus at a time
	wire have_dma = (first_rd != 3'd7) || (first_wr != 3'd7); // [RULE14]
	wire [2:0] sel_ch = (first_rd != 3'd7) ? first_rd : first_wr;

	// ----------------------------------------
	// bus sequencer
	// ----------------------------------------
	logic [1:0] div_q;
	logic [3:0] wait_q;
	logic [2:0] cur_q;
	logic cpu_own_q, rw_q, burst_q;
	logic [15:0] last_addr_q;
	logic valid_last_q;
	wire [1:0] divf = bank_switch_control_reg_q[`DMAXB_BANK_SWITCH_CONTROL_REG_DIV_LSB +: 2];
	wire [3:0] wset_raw = bank_switch_control_reg_q[`DMAXB_BANK_SWITCH_CONTROL_REG_WAIT_LSB +: 4];
	wire [3:0] wset = (wset_raw > `DMAXB_WAIT_MAX) ? `DMAXB_WAIT_MAX : wset_raw; // [RULE6]
	wire consecutive_read_select = bank_switch_control_reg_q[`DMAXB_BANK_SWITCH_CONTROL_REG_CONSECUTIVE_READ_SELECT_BIT];
	wire tick = clk_en && (div_q == divf); // [RULE8]
	wire idle = ph_q == DMAXB_IDLE;
	// arbitration: dma first, cpu held off while bus busy
	wire start_dma = idle && have_dma; // [RULE10]
	wire start_cpu = idle && !have_dma && cpureq_q;
	assign cpu_stall = cpureq_q && !(ph_q != DMAXB_IDLE && cpu_own_q); // [RULE16]

	wire [15:0] nxt_addr = ext_src(mode_q[sel_ch]) ? src_q[sel_ch] : dst_q[sel_ch];
	wire nxt_rd = ext_src(mode_q[sel_ch]);
	wire bank_cross = valid_last_q
		&& nxt_addr[`DMAXB_BANK_BIT] != last_addr_q[`DMAXB_BANK_BIT]; // [RULE5]
	// a following read of the same channel may stay in the active phase
	wire cont_burst = rw_q && consecutive_read_select && !cpu_own_q && legal[cur_q] && ext_src(mode_q[cur_q])
		&& cnt_q[cur_q] != 16'h0001
		&& src_q[cur_q][`DMAXB_BANK_BIT] == last_addr_q[`DMAXB_BANK_BIT]; // [RULE2]
	wire act_done = ph_q == DMAXB_ACT && tick && wait_q == 4'h0; // [RULE7]
	wire dma_beat = act_done && !cpu_own_q;

	dmaxb_phase_t ph_d;
	always_comb begin
		ph_d = ph_q;
		case (ph_q)
			DMAXB_IDLE: if (start_dma || start_cpu) ph_d = bank_cross ? DMAXB_BANK : DMAXB_LEAD;
			DMAXB_BANK: if (tick) ph_d = DMAXB_LEAD;
			DMAXB_LEAD: if (tick) ph_d = DMAXB_ACT; // [RULE1] [RULE3]
			DMAXB_ACT: if (act_done) ph_d = cont_burst ? DMAXB_ACT : DMAXB_TRAIL;
			DMAXB_TRAIL: if (tick) ph_d = DMAXB_IDLE;
			default: ph_d = DMAXB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ph_q <= DMAXB_IDLE;
			div_q <= 2'd0;
			wait_q <= 4'h0;
			cur_q <= 3'd0;
			cpu_own_q <= 1'b0;
			rw_q <= 1'b0;
			burst_q <= 1'b0;
			last_addr_q <= 16'h0000;
			valid_last_q <= 1'b0;
		end else if (clk_en) begin
			ph_q <= ph_d;
			// divider runs only while a sequence is open
			div_q <= (idle || tick) ? 2'd0 : div_q + 2'd1; // [RULE4]
			if (ph_d == DMAXB_ACT && (ph_q != DMAXB_ACT || act_done))
				wait_q <= wset;
			else if (ph_q == DMAXB_ACT && tick && wait_q != 4'h0)
				wait_q <= wait_q - 4'h1;
			if (idle && (start_dma || start_cpu)) begin
				cur_q <= sel_ch;
				cpu_own_q <= !start_dma;
				rw_q <= start_dma ? nxt_rd : 1'b1;
				last_addr_q <= start_dma ? nxt_addr : 16'h0000;
				valid_last_q <= start_dma;
			end
			burst_q <= ph_d == DMAXB_ACT && ph_q == DMAXB_ACT;
		end
	end

	// ----------------------------------------
	// bus pins
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_clock_out <= 1'b0;
			xbus_addr <= 16'h0000;
			xbus_wdata <= 16'h0000;
			xbus_strobe_n <= 1'b1;
			xbus_rw <= 1'b1;
			xbus_space <= 2'b00;
			xbus_data_oe <= 1'b0;
			xbus_bank_cycle <= 1'b0;
			xbus_clk_gate <= 1'b0;
			xin1_q <= 16'h0000;
			xin2_q <= 16'h0000;
		end else if (clk_en) begin
			xin1_q <= xbus_rdata;
			xin2_q <= xin1_q;
			// follows the gate so no edge escapes once the sequence closes
			bus_clock_out <= ph_d != DMAXB_IDLE && (div_q < {1'b0, divf[1]}); // [RULE8]
			xbus_clk_gate <= ph_d != DMAXB_IDLE; // [RULE4]
			xbus_bank_cycle <= ph_d == DMAXB_BANK;
			xbus_strobe_n <= ph_d != DMAXB_ACT;
			xbus_rw <= rw_q;
			xbus_data_oe <= !rw_q && ph_d != DMAXB_IDLE && ph_d != DMAXB_BANK;
			xbus_addr <= cpu_own_q ? 16'h0000 : (rw_q ? src_q[cur_q] : dst_q[cur_q]);
			xbus_space <= mode_q[cur_q][1:0]; // [RULE20]
			xbus_wdata <= rdata_q; // [RULE17]
		end
	end

	// ----------------------------------------
	// channel context and enables
	// ----------------------------------------
	function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
		input logic [15:0] ix);
		case (m)
			2'b01: return a + 16'h0001;
			2'b10: return a - 16'h0001;
			2'b11: return a + ix;
			default: return a;
		endcase
	endfunction : step

	wire [NCH-1:0] done_w = dma_beat && cnt_q[cur_q] == 16'h0001
		? NCH'(1) << cur_q : '0;
	wire [NCH-1:0] cesc_sel = pwdata[NCH-1:0];
	wire cesc_set = pwdata[`DMAXB_CESC_SET_BIT];

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			wire wr_me = wr_acc && ch_ok && reg_ch == 3'(gi);
			wire beat = dma_beat && cur_q == 3'(gi);
			wire [15:0] half = {1'b0, len_q[gi][15:1]};
			always_ff @(posedge core_clk) begin
				if (rst) begin
					mode_q[gi] <= `DMAXB_MODE_RESET; // [RULE19]
					src_q[gi] <= 16'h0000;
					dst_q[gi] <= 16'h0000;
					cnt_q[gi] <= 16'h0000;
					len_q[gi] <= 16'h0000;
					idx_q[gi] <= 16'h0000;
					en_q[gi] <= 1'b0;
					chan_int[gi] <= 1'b0;
				end else if (clk_en) begin
					if (wr_me && reg_grp == `DMAXB_MODE_BASE)
						mode_q[gi] <= pwdata[15:0];
					if (wr_me && reg_grp == `DMAXB_IDX_BASE)
						idx_q[gi] <= pwdata[15:0];
					if (wr_me && reg_grp == `DMAXB_CNT_BASE) begin
						cnt_q[gi] <= pwdata[15:0];
						len_q[gi] <= pwdata[15:0];
					end else if (beat)
						cnt_q[gi] <= cnt_q[gi] - 16'h0001;
					if (wr_me && reg_grp == `DMAXB_SRC_BASE)
						src_q[gi] <= pwdata[15:0];
					else if (beat && rw_q)
						src_q[gi] <= step(src_q[gi], mode_q[gi][9:8], idx_q[gi]); // [RULE11]
					if (wr_me && reg_grp == `DMAXB_DST_BASE)
						dst_q[gi] <= pwdata[15:0];
					else if (beat && !rw_q)
						dst_q[gi] <= step(dst_q[gi], mode_q[gi][3:2], idx_q[gi]); // [RULE11]
					// completion clear wins over a set/clear or enable write in the same cycle
					if (done_w[gi])
						en_q[gi] <= 1'b0; // [RULE21] [RULE24]
					else if (wr_acc && hit_cesc && cesc_sel[gi])
						en_q[gi] <= cesc_set; // [RULE22]
					else if (wr_acc && hit_prec)
						en_q[gi] <= pwdata[gi];
					chan_int[gi] <= beat && mode_q[gi][`DMAXB_MODE_DINT_BIT] // [RULE23]
						&& (cnt_q[gi] == 16'h0001 || (mode_q[gi][`DMAXB_MODE_CHANNEL_INTERRUPT_MODE_BIT]
						&& cnt_q[gi] - 16'h0001 == half)); // [RULE12]
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bank_switch_control_reg_q <= `DMAXB_BANK_SWITCH_CONTROL_REG_RESET;
			cpureq_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else if (clk_en) begin
			if (wr_acc && hit_bank_switch_control_reg)
				bank_switch_control_reg_q <= pwdata[15:0];
			if (wr_acc && hit_cpur)
				cpureq_q <= pwdata[0];
			else if (act_done && cpu_own_q)
				cpureq_q <= 1'b0;
			if (dma_beat && rw_q)
				rdata_q <= xin2_q; // [RULE13]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_lead_act;
		ph_q == DMAXB_LEAD ##1 ph_q == DMAXB_ACT;
	endsequence
	lone_cycle_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE1] [RULE3]
		(clk_en && divf == 2'd0 && wset == 4'h0 && !consecutive_read_select && ph_q == DMAXB_LEAD
		&& $past(ph_q) == DMAXB_IDLE) |=> ph_q == DMAXB_ACT ##1 ph_q == DMAXB_TRAIL
		##1 ph_q == DMAXB_IDLE) else $error("lone cycle broken");
	lead_order_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
		(ph_q == DMAXB_LEAD && tick) |=> ph_q == DMAXB_ACT) else $error("lead not followed");
	lead_len_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
		(clk_en && divf == 2'd0 && ph_q == DMAXB_LEAD) |=> ph_q == DMAXB_ACT)
		else $error("lead phase length");
	trail_end_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
		(ph_q == DMAXB_TRAIL && tick) |=> ph_q == DMAXB_IDLE) else $error("trail too long");
	wait_cap_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
		wait_q <= `DMAXB_WAIT_MAX) else $error("wait count over limit");
	dma_first_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
		(clk_en && idle && have_dma) |=> !cpu_own_q) else $error("cpu beat dma");
	done_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE21]
		(clk_en && done_w != '0) |=> (en_q & $past(done_w)) == '0) else $error("enable kept");
	no_int_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE23]
		(clk_en && $past(!mode_q[cur_q][`DMAXB_MODE_DINT_BIT] && cur_q == 3'd0))
		|-> !chan_int[0]) else $error("masked interrupt");
	cesc_set_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
		(wr_acc && hit_cesc && cesc_set && done_w == '0) |=> (en_q & $past(cesc_sel))
		== $past(cesc_sel)) else $error("set/clear missed");
endmodule : dmaxb_top

//--- dmaxb_xmem.sv
`timescale 1ns/1ps
// ----------------------------------------
// external memory on the parallel bus
// ----------------------------------------
module dmaxb_xmem (
	input wire logic core_clk,
	input wire logic [15:0] xbus_addr,
	input wire logic [15:0] xbus_wdata,
	input wire logic xbus_data_oe,
	input wire logic xbus_strobe_n,
	input wire logic xbus_rw,
	output logic [15:0] xbus_rdata
);
	logic [15:0] mem_q [0:255];
	logic [15:0] junk_q;
	logic [15:0] last_waddr;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_q[i] = 16'(i) ^ 16'ha5a5;
		end
		junk_q = 16'h0000;
		last_waddr = 16'hffff;
	end
	// released bus toggles so a stale value never reads as valid
	always @(posedge core_clk) begin
		junk_q <= ~junk_q;
		if (!xbus_strobe_n && !xbus_rw && xbus_data_oe) begin
			mem_q[xbus_addr[7:0]] <= xbus_wdata;
			last_waddr <= xbus_addr;
		end
	end
	assign xbus_rdata = (!xbus_strobe_n && xbus_rw) ? mem_q[xbus_addr[7:0]] : junk_q;
endmodule : dmaxb_xmem

//--- dmaxb_top_test.sv
`timescale 1ns/1ps
`include "dmaxb_regs.svh"
module dmaxb_top_test;
	import dmaxb_pkg::*;
	logic core_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic bus_clock_out, xbus_data_oe, xbus_strobe_n, xbus_rw, xbus_bank_cycle;
	logic xbus_clk_gate, cpu_stall;
	logic [15:0] xbus_addr, xbus_wdata, xbus_rdata;
	logic [1:0] xbus_space;
	logic [5:0] chan_int;
	int error_cnt, tests_run, low_cnt, gate_cnt, bank_cnt, seed;
	logic [15:0] act_addr;
	logic act_rw;
	dmaxb_top #(.NCH(6)) uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_clock_out(bus_clock_out),
		.xbus_addr(xbus_addr), .xbus_wdata(xbus_wdata), .xbus_data_oe(xbus_data_oe),
		.xbus_rdata(xbus_rdata), .xbus_strobe_n(xbus_strobe_n), .xbus_rw(xbus_rw),
		.xbus_space(xbus_space), .xbus_bank_cycle(xbus_bank_cycle),
		.xbus_clk_gate(xbus_clk_gate), .cpu_stall(cpu_stall), .chan_int(chan_int));
	dmaxb_xmem xm (.core_clk(core_clk), .xbus_addr(xbus_addr), .xbus_wdata(xbus_wdata),
		.xbus_data_oe(xbus_data_oe), .xbus_strobe_n(xbus_strobe_n), .xbus_rw(xbus_rw),
		.xbus_rdata(xbus_rdata));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// bus monitor
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rst === 1'b0) begin
			if (xbus_strobe_n === 1'b0) begin
				low_cnt++;
				act_addr = xbus_addr;
				act_rw = xbus_rw;
			end
			if (xbus_clk_gate === 1'b1) gate_cnt++;
			if (xbus_bank_cycle === 1'b1) bank_cnt++;
			if (xbus_clk_gate === 1'b0) chk(32'(bus_clock_out), 0, "clock while idle");
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
	endtask : rd
	// one channel 0 element run; waits for the enable bit to drop
	task automatic run(input logic [15:0] mode, input logic [15:0] src, input logic [15:0] dst,
		input logic [15:0] bank_switch_control_reg, input logic [15:0] cnt);
		logic [31:0] r;
		wr(`DMAXB_MODE_BASE, {16'h0000, mode});
		wr(`DMAXB_SRC_BASE, {16'h0000, src});
		wr(`DMAXB_DST_BASE, {16'h0000, dst});
		wr(`DMAXB_BANK_SWITCH_CONTROL_REG_ADDR, {16'h0000, bank_switch_control_reg});
		wr(`DMAXB_CNT_BASE, {16'h0000, cnt});
		low_cnt = 0;
		gate_cnt = 0;
		bank_cnt = 0;
		wr(`DMAXB_CESC_ADDR, 32'h0000_8001);
		for (int i = 0; i < 300; i++) begin
			rd(`DMAXB_PREC_ADDR, r);
			if (r[0] === 1'b0) break;
		end
		// let the trailing phase close before lengths are compared
		repeat (8) @(posedge core_clk);
		chk(r[5:0], 6'h00, "enable after done");
	endtask : run
	function automatic logic [31:0] tick_len(input int phases, input int dv);
		return 32'(phases * (dv + 1));
	endfunction : tick_len
	task automatic conclude();
		$display("tests %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		#500_000;
		error_cnt++;
		conclude();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r, v, d;
		logic e;
		logic [5:0] en;
		int w, dv;
		seed = 15147;
		error_cnt = 0;
		tests_run = 0;
		low_cnt = 0;
		gate_cnt = 0;
		bank_cnt = 0;
		rst = 1'b1;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(`DMAXB_MODE_BASE, r);
		chk(r, 32'h0000_0000, "mode reset");
		rd(`DMAXB_BANK_SWITCH_CONTROL_REG_ADDR, r);
		chk(r, 32'h0000_0000, "bank ctrl reset");
		apb(12'hffc, 1'b0, 32'h0000_0000, r, e);
		chk({r[30:0], e}, 32'h0000_0001, "unmapped read");
		// reserved destination space keeps every channel parked
		for (int c = 0; c < 6; c++) begin
			wr(`DMAXB_MODE_BASE + 12'(4 * c), 32'h0000_0803);
			wr(`DMAXB_CNT_BASE + 12'(4 * c), 32'h0000_0001);
		end
		en = 6'h00;
		for (int i = 0; i < 24; i++) begin
			v = (i == 0) ? 32'h0000_8021 : (i == 1) ? 32'h0000_0002 : $random(seed);
			d = {16'h0000, v[15], 9'h000, v[5:0]};
			en = v[15] ? (en | v[5:0]) : (en & ~v[5:0]);
			wr(`DMAXB_CESC_ADDR, d);
			rd(`DMAXB_PREC_ADDR, r);
			chk(r[5:0], en, "set/clear");
		end
		chk(32'(low_cnt), 0, "reserved space ran");
		wr(`DMAXB_CESC_ADDR, 32'h0000_003f);
		// single external reads over every divide and several wait counts
		for (int k = 0; k < 12; k++) begin
			dv = k % 4;
			w = (k < 4) ? 0 : (k < 8) ? 14 : ($random(seed) & 32'h7);
			v = $random(seed) & 32'h0000_3ffe;
			run(16'h0841, v[15:0], 16'h0100, 16'((dv << 12) | (w << 4)), 16'h0001);
			chk(32'(low_cnt), tick_len(w + 1, dv), "active width");
			chk(32'(gate_cnt), tick_len(w + 3, dv), "read length");
			chk({act_rw, act_addr}, {1'b1, v[15:0]}, "read address");
		end
		// single external write with two wait states
		run(16'h0061, 16'h0200, 16'h0044, 16'h0020, 16'h0001);
		chk(32'(gate_cnt), 32'd5, "write length");
		chk({act_rw, xm.last_waddr}, {1'b0, 16'h0044}, "write address");
		// consecutive burst: one active cycle per read
		run(16'h0941, 16'h0010, 16'h0300, 16'h0001, 16'h0003);
		chk(32'(low_cnt), 32'd3, "burst actives");
		// crossing the 32K boundary needs a bank cycle
		run(16'h0941, 16'h7fff, 16'h0300, 16'h0000, 16'h0002);
		chk(32'(bank_cnt != 0), 32'd1, "bank cycle");
		// both ends external must never start
		wr(`DMAXB_MODE_BASE, 32'h0000_0861);
		wr(`DMAXB_CNT_BASE, 32'h0000_0001);
		low_cnt = 0;
		wr(`DMAXB_CESC_ADDR, 32'h0000_8001);
		repeat (60) @(posedge core_clk);
		rd(`DMAXB_PREC_ADDR, r);
		chk({r[0], 31'(low_cnt)}, {1'b1, 31'd0}, "ext to ext refused");
		conclude();
	end
endmodule : dmaxb_top_test
